/* File: verilog/pcp_config_bank.sv */
module pcp_config_bank
  import pcp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire pcp_cfg_s    i_cfg,
  input  wire logic        i_win_wr,
  input  wire logic [31:0] i_win_data,
  input  wire pcp_prom_s   i_prom,
  input  wire logic        i_prom_abort,
  input  wire logic        i_prom_load_disable,
  input  wire logic        i_aux_sense,
  output logic [31:0]      o_rdata,
  output logic             o_rvalid,
  output logic             o_prom_start,
  output logic             o_load_busy
);
  pcp_state_s s_r;
  pcp_state_s s_nxt;
  logic [15:0] cap_word;
  logic [15:0] ctl_word;
  logic [31:0] drv_word;
  logic [31:0] rd_mux;
  logic        wr_en;
  logic [31:0] wmask;

  // Capability halfword assembled from fixed and shadowed bits
  always_comb begin
    cap_word        = 16'h0000;
    cap_word[15]    = 1'b0;
    cap_word[14:11] = {4{s_r.wake_shd}};
    cap_word[10]    = 1'b1;
    cap_word[9]     = 1'b1;
    cap_word[8:6]   = i_aux_sense ? s_r.aux_shd : 3'h0;
    cap_word[5]     = 1'b1;
    cap_word[2:0]   = PM_VERSION;
  end

  // Control/status halfword; data fields and reserved bits stay zero
  always_comb begin
    ctl_word              = 16'h0000;
    ctl_word[CS_WAKE_STS] = s_r.wake_sts;
    ctl_word[CS_WAKE_EN]  = s_r.wake_en;
    ctl_word[1:0]         = s_r.pwr_state;
  end

  // Driver config; bits 26-24 reserved and read zero
  assign drv_word = {s_r.wake_shd, s_r.rsvd_rw, s_r.aux_shd, 3'h0, s_r.gp_cfg};

  // Byte lane mask from the byte enables
  assign wmask = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};
  // Config access only honoured once the reset copy is released
  assign wr_en = i_cfg.wr & s_r.rst_sync;

  // Read decode; unmapped and shadow offsets read zero
  always_comb begin
    case (i_cfg.addr)
      OFS_SUBSYS:  rd_mux = {s_r.sub_id, s_r.sub_vendor};
      OFS_ROM:     rd_mux = ZERO_WORD;
      OFS_RSVD_A:  rd_mux = ZERO_WORD;
      OFS_RSVD_B:  rd_mux = ZERO_WORD;
      OFS_LATGNT:  rd_mux = {MAX_LAT, MIN_GNT, INT_PIN, s_r.int_line};
      OFS_PWR_CAP: rd_mux = {cap_word, NEXT_PTR, CAP_ID};
      OFS_PWR_CTL: rd_mux = {8'h00, 8'h00, ctl_word};
      OFS_DRV_CFG: rd_mux = drv_word;
      OFS_SHADOW:  rd_mux = ZERO_WORD;
      default:     rd_mux = ZERO_WORD;
    endcase
  end

  // Next-state logic for every register of the bank
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rst_meta = 1'b1;
    s_nxt.rst_sync = s_r.rst_meta;
    s_nxt.rvalid   = i_cfg.rd & s_r.rst_sync;
    s_nxt.rdata    = (i_cfg.rd & s_r.rst_sync) ? rd_mux : ZERO_WORD;

    // Prom loader sequencing; the loader engine itself sits outside
    case (s_r.load)
      LD_WAIT: begin
        if (s_r.rst_sync) begin
          s_nxt.load = i_prom_load_disable ? LD_DONE : LD_BUSY;
        end
      end
      LD_BUSY: begin
        if (i_prom.valid) begin
          s_nxt.sub_id     = i_prom.sub_id;
          s_nxt.sub_vendor = i_prom.sub_vendor;
          s_nxt.gp_cfg[15:0] = i_prom.cfg;
          s_nxt.load       = LD_DONE;
        end else if (i_prom_abort) begin
          s_nxt.load = LD_DONE;
        end
      end
      LD_DONE: s_nxt.load = LD_DONE;
      default: s_nxt.load = LD_DONE;
    endcase
    // Loader status pins follow the next state so they leave straight from flops
    s_nxt.prom_start = (s_nxt.load == LD_BUSY);
    s_nxt.load_busy  = (s_nxt.load != LD_DONE);

    // Memory window write; lower half vendor, upper half subsystem
    if (i_win_wr) begin
      s_nxt.sub_vendor = i_win_data[15:0];
      s_nxt.sub_id     = i_win_data[31:16];
    end

    // Configuration writes; read-only fields simply have no path
    if (wr_en) begin
      case (i_cfg.addr)
        OFS_SHADOW: begin
          if (i_cfg.be[0]) s_nxt.sub_vendor[7:0]  = i_cfg.data[7:0];
          if (i_cfg.be[1]) s_nxt.sub_vendor[15:8] = i_cfg.data[15:8];
          if (i_cfg.be[2]) s_nxt.sub_id[7:0]      = i_cfg.data[23:16];
          if (i_cfg.be[3]) s_nxt.sub_id[15:8]     = i_cfg.data[31:24];
        end
        OFS_LATGNT: begin
          if (i_cfg.be[0]) s_nxt.int_line = i_cfg.data[7:0];
        end
        OFS_PWR_CTL: begin
          if (i_cfg.be[0]) s_nxt.pwr_state = i_cfg.data[1:0];
          if (i_cfg.be[1]) begin
            s_nxt.wake_en  = i_cfg.data[CS_WAKE_EN];
            s_nxt.wake_sts = i_cfg.data[CS_WAKE_STS];
          end
        end
        OFS_DRV_CFG: begin
          s_nxt.gp_cfg = (s_r.gp_cfg & ~wmask[23:0]) | (i_cfg.data[23:0] & wmask[23:0]);
          if (i_cfg.be[3]) begin
            s_nxt.wake_shd = i_cfg.data[DC_WAKE_SHD];
            s_nxt.rsvd_rw  = i_cfg.data[DC_RSVD_RW];
          end
        end
        default: ;
      endcase
    end
  end

  // Asynchronous reset to constants; release is synchronised through rst_meta/rst_sync
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r           <= '0;
      s_r.load      <= LD_WAIT;
      s_r.load_busy <= 1'b1;  // Busy until the load ends or is skipped
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata      = s_r.rdata;
  assign o_rvalid     = s_r.rvalid;
  assign o_prom_start = s_r.prom_start;
  assign o_load_busy  = s_r.load_busy;
endmodule

/* File: verilog/pcp_pkg.sv */
package pcp_pkg;
  localparam logic [7:0] OFS_SUBSYS   = 8'h2c;
  localparam logic [7:0] OFS_ROM      = 8'h30;
  localparam logic [7:0] OFS_RSVD_A   = 8'h34;
  localparam logic [7:0] OFS_RSVD_B   = 8'h38;
  localparam logic [7:0] OFS_LATGNT   = 8'h3c;
  localparam logic [7:0] OFS_PWR_CAP  = 8'h40;
  localparam logic [7:0] OFS_PWR_CTL  = 8'h44;
  localparam logic [7:0] OFS_DRV_CFG  = 8'hf8;
  localparam logic [7:0] OFS_SHADOW   = 8'hfc;
  localparam logic [7:0] MAX_LAT      = 8'h18;
  localparam logic [7:0] MIN_GNT      = 8'h04;
  localparam logic [7:0] INT_PIN      = 8'h01;
  localparam logic [7:0] CAP_ID       = 8'h01;
  localparam logic [7:0] NEXT_PTR     = 8'h00;
  localparam logic [2:0] PM_VERSION   = 3'h2;
  localparam int         CS_WAKE_STS  = 15;
  localparam int         CS_WAKE_EN   = 8;
  localparam int         DC_WAKE_SHD  = 31;
  localparam int         DC_RSVD_RW   = 30;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // Serial prom words fetched by the loader
  typedef struct packed {
    logic        valid;   // Strobe for one cycle with a good signature
    logic [15:0] sub_vendor;
    logic [15:0] sub_id;
    logic [15:0] cfg;     // Two bytes of general configuration
  } pcp_prom_s;

  // Configuration cycle request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } pcp_cfg_s;

  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_BUSY = 2'b01,
    LD_DONE = 2'b11
  } pcp_load_e;

  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    pcp_load_e   load;
    logic [15:0] sub_id;
    logic [15:0] sub_vendor;
    logic [7:0]  int_line;
    logic [7:0]  lat_timer;
    logic        wake_sts;
    logic        wake_en;
    logic [1:0]  pwr_state;
    logic        wake_shd;
    logic        rsvd_rw;
    logic [2:0]  aux_shd;
    logic [23:0] gp_cfg;
    logic [31:0] rdata;
    logic        rvalid;
    logic        prom_start;  // Kept as a flop so the pin has no decode gates
    logic        load_busy;
  } pcp_state_s;
endpackage

/* File: test/pcp_checker.sv */
module pcp_checker
  import pcp_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire pcp_cfg_s    i_cfg,
  input wire logic        i_aux_sense,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Read request at one offset
  sequence s_rd(logic [7:0] a);
    i_cfg.rd && i_cfg.addr == a;
  endsequence
  property p_ans; i_cfg.rd |=> o_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_quiet; !i_cfg.rd |=> !o_rvalid && o_rdata == ZERO_WORD; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious read data");
  property p_zero; s_rd(OFS_ROM) or s_rd(OFS_RSVD_A) or s_rd(OFS_RSVD_B) or s_rd(OFS_SHADOW)
    |=> o_rdata == ZERO_WORD; endproperty
  a_zero: assert property (p_zero) else $error("zero word not zero");
  property p_cap; s_rd(OFS_PWR_CAP) |=> {o_rdata[26:25], o_rdata[21:0]}
    == {3'h7, 2'h0, PM_VERSION, NEXT_PTR, CAP_ID}; endproperty
  a_cap: assert property (p_cap) else $error("fixed capability bits");
  property p_wake; s_rd(OFS_PWR_CAP) |=> !o_rdata[31] && $countones(o_rdata[30:27]) % 4 == 0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake support bits split");
  property p_aux; s_rd(OFS_PWR_CAP) ##0 !i_aux_sense |=> o_rdata[24:22] == 3'h0; endproperty
  a_aux: assert property (p_aux) else $error("aux current without sense");
  property p_ctl; s_rd(OFS_PWR_CTL) |=> o_rdata[31:16] == 16'h0 && o_rdata[14:2] ==? 13'b0_0000_0?00_0000;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control reserved bits");
  property p_drv; s_rd(OFS_DRV_CFG) |=> o_rdata[26:24] == 3'h0; endproperty
  a_drv: assert property (p_drv) else $error("config reserved bits");
endmodule
bind pcp_config_bank pcp_checker i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg(i_cfg),
  .i_aux_sense(i_aux_sense), .o_rdata(o_rdata), .o_rvalid(o_rvalid));

/* File: test/pcp_host_model.sv */
module pcp_host_model
  import pcp_pkg::*;
(
  input wire logic i_clk,
  output pcp_cfg_s o_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_cfg = '0;
  // One config cycle held over its sampling edge; release costs a cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
    @(negedge i_clk);
    o_cfg <= '{w, !w, a, b, d};
    @(negedge i_clk);
    o_cfg <= '0;
  endtask
endmodule

/* File: test/test_pci_config_power_mgmt.sv */
module test_pci_config_power_mgmt import pcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, win_wr = 1'b0, aux = 1'b0, rvalid, pstart, busy;
  logic        pdis = 1'b0, pabort = 1'b0;
  logic [31:0] win_d = '0, rdata, seed = 32'h1bfc;
  logic [31:0] exp_q[$];
  logic [7:0]  ofs[7] = '{OFS_SUBSYS, OFS_ROM, OFS_RSVD_B, OFS_LATGNT, OFS_PWR_CAP,
                          OFS_PWR_CTL, OFS_DRV_CFG};
  pcp_prom_s   prom = '0;
  pcp_cfg_s    cfg;
  int          bad_count = 0, tests_run = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  pcp_host_model i_host (.i_clk(clk), .o_cfg(cfg));
  pcp_config_bank i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_cfg(cfg), .i_win_wr(win_wr),
    .i_win_data(win_d), .i_prom(prom), .i_prom_abort(pabort), .i_prom_load_disable(pdis),
    .i_aux_sense(aux), .o_rdata(rdata), .o_rvalid(rvalid), .o_prom_start(pstart),
    .o_load_busy(busy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The note goes in before the request so the watcher never runs dry
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 4'hf, '0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watcher pairs each answered read with the oldest note; falling edge, answer settled
  always @(negedge clk) begin
    if (rvalid === 1'b1)
      check(rdata, exp_q.pop_front());
  end
  // Watchdog far above the few hundred cycles needed
  initial begin
    #75000;
    bad_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [31:0] v, p, s;
    v = rnd();
    p = rnd();
    repeat (20) @(negedge clk);
    check(busy, 1'b1);
    check(pstart, 1'b0);
    rst_n = 1'b1;
    for (int n = 0; n < 50 && pstart !== 1'b1; n++) @(negedge clk);
    check(pstart, 1'b1);
    prom <= '{1'b1, v[15:0], v[31:16], p[15:0]};
    @(negedge clk);
    prom <= '0;
    for (int n = 0; n < 50 && busy !== 1'b0; n++) @(negedge clk);
    check(busy, 1'b0);
    check(pstart, 1'b0);
    // Defaults, then the same words after all-ones writes
    for (int k = 0; k < 2; k++) begin
      rd(OFS_SUBSYS, v);
      rd(OFS_ROM, ZERO_WORD);
      rd(OFS_RSVD_B, ZERO_WORD);
      rd(OFS_RSVD_A, ZERO_WORD);
      rd(8'hf4, ZERO_WORD);
      rd(OFS_SHADOW, ZERO_WORD);
      rd(OFS_LATGNT, {MAX_LAT, MIN_GNT, INT_PIN, k ? 8'hff : 8'h00});
      rd(OFS_PWR_CAP, {k ? 5'h0f : 5'h00, 11'h622, NEXT_PTR, CAP_ID});
      rd(OFS_PWR_CTL, k ? 32'h0000_8103 : ZERO_WORD);
      rd(OFS_DRV_CFG, k ? 32'hc0ff_ffff : {16'h0, p[15:0]});
      foreach (ofs[j]) i_host.xfer(1'b1, ofs[j], 4'hf, '1);
    end
    $display("test defaults and write masks done");
    aux = 1'b1;
    i_host.xfer(1'b1, OFS_DRV_CFG, 4'h8, '0);
    i_host.xfer(1'b1, OFS_PWR_CTL, 4'h1, '0);
    rd(OFS_PWR_CAP, {16'h0622, NEXT_PTR, CAP_ID});
    rd(OFS_DRV_CFG, 32'h00ff_ffff);
    rd(OFS_PWR_CTL, 32'h0000_8100);
    s = rnd();
    i_host.xfer(1'b1, OFS_SHADOW, 4'h3, s);
    i_host.xfer(1'b1, OFS_SHADOW, 4'hc, ~s);
    rd(OFS_SUBSYS, {~s[31:16], s[15:0]});
    win_d <= rnd();
    win_wr <= 1'b1;
    @(negedge clk);
    win_wr <= 1'b0;
    rd(OFS_SUBSYS, win_d);
    for (int n = 0; n < 20 && exp_q.size() > 0; n++) @(negedge clk);
    if (exp_q.size() > 0)
      bad_count++;
    $display("test shadow and window writes done");
    // Mid-run resets: first with the load skipped, then with a bad signature
    for (int m = 0; m < 2; m++) begin
      rst_n = 1'b0;
      pdis  = (m == 0);
      repeat (2) @(negedge clk);
      check(busy, 1'b1);
      rst_n = 1'b1;
      for (int n = 0; n < 8 && busy !== 1'b0 && pstart !== 1'b1; n++) @(negedge clk);
      check(pstart, m == 1);
      pabort <= 1'b1;
      @(negedge clk);
      pabort <= 1'b0;
      for (int n = 0; n < 8 && busy !== 1'b0; n++) @(negedge clk);
      check(busy, 1'b0);
      check(pstart, 1'b0);
      rd(OFS_SUBSYS, ZERO_WORD);
      rd(OFS_DRV_CFG, ZERO_WORD);
      rd(OFS_PWR_CTL, ZERO_WORD);
      rd(OFS_LATGNT, {MAX_LAT, MIN_GNT, INT_PIN, 8'h00});
    end
    for (int n = 0; n < 20 && exp_q.size() > 0; n++) @(negedge clk);
    if (exp_q.size() > 0)
      bad_count++;
    $display("test mid-run resets done");
    end_of_test();
  end
endmodule
